// ==== logic/ebrw_ctrl.sv ====
// External bus cycle controller with wait states and ready termination
// How it works
// - A ready sampled high at the sample point adds a wait state, sampled low ends the cycle.
// - Each cycle includes the programmed count of cycle-time wait states, possibly zero.
// - The command's leading edge is one half period later when read/write delay is enabled.
// - Multiplexed cycles end with a mux wait state and an optional tristate wait state.
// - The gap is two clock-output cycles for mux with tristate and zero for demux without it.
// - Read data are captured on the edge that ends the strobe; the address holds until the next command.
// - Mux and tristate options for the spacing are read live as the current cycle ends.
`timescale 1ns/1ps
module ebrw_ctrl (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic rst_b,
    input wire logic clk_en,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // External bus pins
    output logic system_clock_output,
    output logic ale,
    output logic read_chip_select_b,
    output logic write_chip_select_b,
    output logic high_byte_enable_b,
    output logic [15:0] addr_out,
    input wire logic [15:0] data_in,
    output logic [15:0] data_out,
    output logic data_oe,
    input wire logic ready_b
);
    ebrw_pkg::ebrw_state_t st_q, st_d;
    logic [31:0] ctrl_q;
    logic [31:0] cmd_q;
    logic [15:0] wdata_q;
    logic [15:0] rdata_q;
    logic pend_q, done_q;
    logic [3:0] ws_q;
    logic co_q;
    logic write_q;
    logic gap_q;
    ebrw_sync_if sif ();

    // ==========================================================
    // Register decode
    wire wr_en = psel && penable && pwrite;
    wire rd_sel_ctrl = paddr == ebrw_pkg::ADDR_CTRL;
    wire rd_sel_cmd = paddr == ebrw_pkg::ADDR_CMD;
    wire rd_sel_wd = paddr == ebrw_pkg::ADDR_WDATA;
    wire rd_sel_st = paddr == ebrw_pkg::ADDR_STATUS;
    wire rd_sel_rd = paddr == ebrw_pkg::ADDR_RDATA;
    wire mapped = rd_sel_ctrl | rd_sel_cmd | rd_sel_wd | rd_sel_st | rd_sel_rd;
    wire busy = (st_q != ebrw_pkg::ST_IDLE) || pend_q;
    wire [3:0] cfg_ws = ctrl_q[ebrw_pkg::CTRL_WS_LSB +: ebrw_pkg::CTRL_WS_W];
    wire cfg_rwdly = ctrl_q[ebrw_pkg::CTRL_RWDLY_BIT];
    wire cfg_mux = ctrl_q[ebrw_pkg::CTRL_MUX_BIT];
    wire cfg_tri = ctrl_q[ebrw_pkg::CTRL_TRI_BIT];
    wire cfg_async = ctrl_q[ebrw_pkg::CTRL_ASYNC_BIT];
    wire cfg_aleext = ctrl_q[ebrw_pkg::CTRL_ALEEXT_BIT];
    wire [31:0] status_w = {30'h0000_0000, done_q, busy};
    wire co_rise = !co_q; // Next edge raises the clock output

    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign prdata = rd_sel_ctrl ? ctrl_q :
                    rd_sel_cmd ? cmd_q :
                    rd_sel_wd ? {16'h0000, wdata_q} :
                    rd_sel_st ? status_w :
                    rd_sel_rd ? {16'h0000, rdata_q} : 32'h0000_0000;

    // ==========================================================
    // Clock output toggles each half period: the cpu rate, half the clk rate
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            co_q <= 1'b0;
        end else if (clk_en) begin
            co_q <= ~co_q;
        end
    end
    assign system_clock_output = co_q;

    // ==========================================================
    // Ready path: async through synchroniser, sync sampled at clock rise
    assign sif.ready_raw = ready_b;
    ebrw_sync u_sync (
        .clk(clk),
        .rst_b(rst_b),
        .clk_en(clk_en),
        .bus(sif.sync)
    );
    // Sync ready is read live and acted on only at the clock output rise;
    // a held sample would add one clock output cycle of ready latency
    wire ready_lvl = cfg_async ? sif.ready_sync : ready_b;

    // ==========================================================
    // Software registers; command launch set wins over the pending clear at cycle start
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_q <= ebrw_pkg::CTRL_RESET;
            cmd_q <= 32'h0000_0000;
            wdata_q <= 16'h0000;
            pend_q <= 1'b0;
        end else if (clk_en) begin
            if (wr_en && rd_sel_ctrl) begin
                ctrl_q <= pwdata;
            end
            if (wr_en && rd_sel_wd) begin
                wdata_q <= pwdata[15:0];
            end
            if (wr_en && rd_sel_cmd && !busy) begin
                cmd_q <= pwdata;
                pend_q <= 1'b1;
            end else if (st_q == ebrw_pkg::ST_IDLE && co_rise) begin
                pend_q <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Cycle sequencer
    wire ws_zero = ws_q == 4'h0;
    wire rdy_end = !ready_lvl; // Low ends the cycle
    // Each gap wait state spans one clock output cycle, two clk steps
    wire in_gap = (st_q == ebrw_pkg::ST_MUXW) || (st_q == ebrw_pkg::ST_TRIW);
    always_comb begin
        st_d = st_q;
        case (st_q)
            ebrw_pkg::ST_IDLE: begin
                // Start on a clock output rise so ready sampling keeps a fixed phase
                if (pend_q && co_rise) begin
                    st_d = ebrw_pkg::ST_ALE;
                end
            end
            ebrw_pkg::ST_ALE: begin
                st_d = (cfg_aleext || cfg_rwdly) ? ebrw_pkg::ST_SETUP : ebrw_pkg::ST_CMD;
            end
            ebrw_pkg::ST_SETUP: begin
                st_d = ebrw_pkg::ST_CMD;
            end
            ebrw_pkg::ST_CMD: begin
                st_d = ws_zero ? ebrw_pkg::ST_RDYS : ebrw_pkg::ST_WAIT;
            end
            ebrw_pkg::ST_WAIT: begin
                if (ws_q == 4'h1) begin
                    st_d = ebrw_pkg::ST_RDYS;
                end
            end
            ebrw_pkg::ST_RDYS: begin
                // Sample only at the clock output rise
                if (co_rise && rdy_end) begin
                    st_d = ebrw_pkg::ST_END;
                end
            end
            ebrw_pkg::ST_END: begin
                st_d = cfg_mux ? ebrw_pkg::ST_MUXW : ebrw_pkg::ST_IDLE;
            end
            ebrw_pkg::ST_MUXW: begin
                if (gap_q) begin
                    st_d = cfg_tri ? ebrw_pkg::ST_TRIW : ebrw_pkg::ST_IDLE;
                end
            end
            ebrw_pkg::ST_TRIW: begin
                if (gap_q) begin
                    st_d = ebrw_pkg::ST_IDLE;
                end
            end
            default: begin
                st_d = ebrw_pkg::ST_IDLE;
            end
        endcase
    end

    // Gap options are read live, so a reconfigure before launch governs it
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_q <= ebrw_pkg::ST_IDLE;
            ws_q <= 4'h0;
            write_q <= 1'b0;
            gap_q <= 1'b0;
        end else if (clk_en) begin
            st_q <= st_d;
            gap_q <= in_gap && !gap_q;
            if (st_q == ebrw_pkg::ST_ALE) begin
                ws_q <= cfg_ws;
                write_q <= cmd_q[ebrw_pkg::CMD_WRITE_BIT];
            end else if (st_q == ebrw_pkg::ST_WAIT) begin
                ws_q <= ws_q - 4'h1;
            end
        end
    end

    // ==========================================================
    // Read capture at the strobe-ending edge
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_q <= 16'h0000;
            done_q <= 1'b0;
        end else if (clk_en) begin
            if (st_q == ebrw_pkg::ST_RDYS && st_d == ebrw_pkg::ST_END) begin
                if (!write_q) begin
                    rdata_q <= data_in;
                end
                done_q <= 1'b1;
            end else if (wr_en && rd_sel_cmd && !busy) begin
                done_q <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Pin drive
    wire in_cmd = (st_q == ebrw_pkg::ST_CMD) || (st_q == ebrw_pkg::ST_WAIT) || (st_q == ebrw_pkg::ST_RDYS);
    wire in_cyc = in_cmd || (st_q == ebrw_pkg::ST_ALE) || (st_q == ebrw_pkg::ST_SETUP);
    assign ale = st_q == ebrw_pkg::ST_ALE;
    assign read_chip_select_b = !(in_cmd && !write_q);
    assign write_chip_select_b = !(in_cmd && write_q);
    assign high_byte_enable_b = !in_cyc;
    assign addr_out = cmd_q[ebrw_pkg::CMD_ADDR_W-1:0];
    assign data_out = wdata_q;
    assign data_oe = in_cmd && write_q;

    // ==========================================================
    // Checks
    AST_RDY_END: assert property (@(posedge clk) disable iff (!rst_b)
        clk_en && st_q == ebrw_pkg::ST_RDYS && co_rise && !ready_lvl |=> st_q == ebrw_pkg::ST_END)
        else $error("ready low did not end cycle");
    AST_RDY_WAIT: assert property (@(posedge clk) disable iff (!rst_b)
        clk_en && st_q == ebrw_pkg::ST_RDYS && ready_lvl |=> st_q == ebrw_pkg::ST_RDYS)
        else $error("ready high did not wait");
    AST_WS_ZERO: assert property (@(posedge clk) disable iff (!rst_b)
        clk_en && st_q == ebrw_pkg::ST_CMD && ws_zero |=> st_q == ebrw_pkg::ST_RDYS)
        else $error("zero wait states not honoured");
    AST_RWDLY: assert property (@(posedge clk) disable iff (!rst_b)
        clk_en && st_q == ebrw_pkg::ST_ALE && cfg_rwdly |=> st_q == ebrw_pkg::ST_SETUP)
        else $error("command not delayed");
    AST_MUXW: assert property (@(posedge clk) disable iff (!rst_b)
        clk_en && st_q == ebrw_pkg::ST_END && cfg_mux |=> st_q == ebrw_pkg::ST_MUXW)
        else $error("mux wait missing");
    AST_GAP_DEMUX: assert property (@(posedge clk) disable iff (!rst_b)
        clk_en && st_q == ebrw_pkg::ST_END && !cfg_mux |=> st_q == ebrw_pkg::ST_IDLE)
        else $error("demux gap not zero");
    AST_RDATA: assert property (@(posedge clk) disable iff (!rst_b)
        clk_en && st_q == ebrw_pkg::ST_RDYS && st_d == ebrw_pkg::ST_END && !write_q
        |=> rdata_q == $past(data_in))
        else $error("read data not captured");
    AST_SYSTEM_CLOCK_OUTPUT: assert property (@(posedge clk) disable iff (!rst_b)
        clk_en |=> system_clock_output != $past(system_clock_output))
        else $error("clock output not halved");
    AST_ASYNC: assert property (@(posedge clk) disable iff (!rst_b)
        clk_en && cfg_async && st_q == ebrw_pkg::ST_RDYS && sif.ready_sync |=> st_q == ebrw_pkg::ST_RDYS)
        else $error("async ready bypassed sync");
    AST_GAP_TRI: assert property (@(posedge clk) disable iff (!rst_b)
        clk_en && st_q == ebrw_pkg::ST_END && cfg_mux && cfg_tri ##1 clk_en [*4] |=> st_q == ebrw_pkg::ST_IDLE)
        else $error("mux tristate gap not two clock output cycles");
    COV_READ: cover property (@(posedge clk) st_q == ebrw_pkg::ST_END && !write_q);
    COV_WRITE: cover property (@(posedge clk) st_q == ebrw_pkg::ST_END && write_q);
    COV_TRI: cover property (@(posedge clk) st_q == ebrw_pkg::ST_TRIW);
endmodule

// ==== logic/ebrw_pkg.sv ====
// Package of constants for the external bus ready/wait cycle controller
package ebrw_pkg;
    // ==========================================================
    // Register map (APB byte addresses)
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_CMD = 8'h04;
    localparam logic [7:0] ADDR_WDATA = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0C;
    localparam logic [7:0] ADDR_RDATA = 8'h10;
    // ==========================================================
    // Control register fields
    localparam int CTRL_WS_LSB = 0;
    localparam int CTRL_WS_W = 4;
    localparam int CTRL_RWDLY_BIT = 4;
    localparam int CTRL_MUX_BIT = 5;
    localparam int CTRL_TRI_BIT = 6;
    localparam int CTRL_ASYNC_BIT = 7;
    localparam int CTRL_ALEEXT_BIT = 8;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    // Command register fields
    localparam int CMD_WRITE_BIT = 16;
    localparam int CMD_ADDR_W = 16;
    // Status fields
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_DONE_BIT = 1;
    // ==========================================================
    // Timing: one state step is one cpu half period (one clk cycle)
    localparam int CLK_PERIOD_NS = 40;
    localparam int HALF_PER_NS = 40;
    localparam int HALF_CYC = (HALF_PER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SYNC_STAGES = 3;
    // ==========================================================
    // Bus cycle states, one-hot
    typedef enum logic [8:0] {
        ST_IDLE = 9'b0_0000_0001,
        ST_ALE = 9'b0_0000_0010,
        ST_SETUP = 9'b0_0000_0100,
        ST_CMD = 9'b0_0000_1000,
        ST_WAIT = 9'b0_0001_0000,
        ST_RDYS = 9'b0_0010_0000,
        ST_END = 9'b0_0100_0000,
        ST_MUXW = 9'b0_1000_0000,
        ST_TRIW = 9'b1_0000_0000
    } ebrw_state_t;
endpackage

// ==== logic/ebrw_sync_if.sv ====
// Interface carrying the ready synchroniser signals
`timescale 1ns/1ps
interface ebrw_sync_if;
    logic ready_raw;
    logic ready_sync;
    modport owner (output ready_raw, input ready_sync);
    modport sync (input ready_raw, output ready_sync);
endinterface

// ==== logic/ebrw_sync.sv ====
// Three-stage synchroniser for the asynchronous ready pin
`timescale 1ns/1ps
module ebrw_sync (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    input wire logic clk_en,
    // Carrier
    ebrw_sync_if.sync bus
);
    logic [ebrw_pkg::SYNC_STAGES-1:0] sh_q;
    logic stable_q;

    // ==========================================================
    // Shift chain; first stage only feeds the second
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sh_q <= '1;
            stable_q <= 1'b1;
        end else if (clk_en) begin
            sh_q <= {sh_q[ebrw_pkg::SYNC_STAGES-2:0], bus.ready_raw};
            if (sh_q[1] == sh_q[2]) begin
                stable_q <= sh_q[2];
            end
        end
    end
    // Change counts once stages two and three agree
    assign bus.ready_sync = stable_q;
endmodule

// ==== bench/ebrw_mem_model.sv ====
// External memory model answering bus commands with ready and read data
`timescale 1ns/1ps
module ebrw_mem_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Command pins from the controller
    input wire logic read_chip_select_b,
    input wire logic write_chip_select_b,
    input wire logic [15:0] addr_out,
    input wire logic [15:0] data_out,
    // Answer delay in clk cycles
    input wire logic [3:0] dly,
    // Answers
    output logic ready_b,
    output logic [15:0] data_in,
    output logic [15:0] last_wdata
);
    logic [3:0] cnt_q;
    logic [15:0] junk_q;
    logic cmd_on;
    // ==========================================================
    // Command decode and read data; junk outside reads so a late capture shows
    assign cmd_on = !read_chip_select_b || !write_chip_select_b;
    assign data_in = !read_chip_select_b ? (addr_out ^ 16'hC3C3) : junk_q;
    // Ready stays low to the end of the command, long enough for any synchroniser
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_q <= 4'h0;
            ready_b <= 1'b1;
            junk_q <= 16'h0F0F;
            last_wdata <= 16'h0000;
        end else begin
            junk_q <= ~junk_q;
            cnt_q <= !cmd_on ? 4'h0 : (cnt_q == 4'hF ? cnt_q : cnt_q + 4'h1);
            ready_b <= !(cmd_on && cnt_q >= dly);
            if (!write_chip_select_b) begin
                last_wdata <= data_out;
            end
        end
    end
endmodule

// ==== bench/ext_bus_ready_wait_control_bench.sv ====
// Self-checking bench for the external bus cycle controller
`timescale 1ns/1ps
module ext_bus_ready_wait_control_bench;
    // ==========================================================
    // Clock, pins and counters
    logic clk = 1'b0;
    logic rst_b = 1'b1;
    logic clk_en = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, system_clock_output, ale, read_chip_select_b, write_chip_select_b;
    logic high_byte_enable_b, data_oe, ready_b, oe_seen, hbe_seen;
    logic [15:0] addr_out, data_in, data_out, last_wdata, a_seen;
    logic [3:0] mdly = 4'h0;
    int n_fail = 0;
    int n_compared = 0;
    int lo, ld, gp, lo0, ld0, gp0;
    // Free-running 25 MHz clock
    always #20 clk = ~clk;
    ebrw_ctrl uut (.clk, .rst_b, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .system_clock_output, .ale, .read_chip_select_b, .write_chip_select_b, .high_byte_enable_b,
        .addr_out, .data_in, .data_out, .data_oe, .ready_b);
    ebrw_mem_model mem (.clk, .rst_b, .read_chip_select_b, .write_chip_select_b, .addr_out, .data_out,
        .dly(mdly), .ready_b, .data_in, .last_wdata);
    // ==========================================================
    // Compare, report and APB tasks
    task automatic chk_v(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_c(input logic ok, input int a, input int b);
        n_compared++;
        if (ok !== 1'b1) begin
            n_fail++;
            $display("Error at %0t: counts %h and %h out of relation", $time, a, b);
        end
    endtask
    task automatic finish_test;
        $display("Compared %0d, mismatched %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic give_up;
        n_fail++;
        $display("Error at %0t: wait ran out, %h %h", $time, 0, 1);
        finish_test();
    endtask
    // One idle cycle before each setup keeps psel from being driven twice at one edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (pready !== 1'b1 && i < 50);
        if (i >= 50) give_up();
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Run one bus cycle; ld counts ale to strobe, lo strobe low, gp status polls
    task automatic cyc(input logic [31:0] ctrl, input logic wr, input logic [15:0] a, input logic [3:0] dly);
        int i;
        mdly <= dly;
        apb(1'b1, ebrw_pkg::ADDR_CTRL, ctrl);
        apb(1'b1, ebrw_pkg::ADDR_WDATA, {16'h0000, ~a});
        apb(1'b1, ebrw_pkg::ADDR_CMD, {15'h0000, wr, a});
        for (i = 0; ale !== 1'b1 && i < 40; i++) begin
            @(posedge clk);
        end
        for (ld = 0; (wr ? write_chip_select_b : read_chip_select_b) !== 1'b0 && ld < 40; ld++) begin
            @(posedge clk);
        end
        a_seen = addr_out;
        oe_seen = data_oe;
        hbe_seen = high_byte_enable_b;
        for (lo = 0; (wr ? write_chip_select_b : read_chip_select_b) !== 1'b1 && lo < 200; lo++) begin
            @(posedge clk);
        end
        gp = 0;
        do begin
            apb(1'b0, ebrw_pkg::ADDR_STATUS, 32'h0000_0000);
            gp++;
        end while (rd[ebrw_pkg::STAT_BUSY_BIT] !== 1'b0 && gp < 40);
        if (i >= 40 || ld >= 40 || lo >= 200 || gp >= 40) give_up();
        apb(1'b0, ebrw_pkg::ADDR_RDATA, 32'h0000_0000);
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_clock;
        logic p;
        for (int k = 0; k < 4; k++) begin
            p = system_clock_output;
            @(posedge clk);
            #1 chk_v(system_clock_output, !p);
        end
        @(posedge clk);
        clk_en <= 1'b0;
        @(posedge clk);
        #1 p = system_clock_output;
        repeat (3) @(posedge clk);
        chk_v(system_clock_output, p);
        clk_en <= 1'b1;
        $display("clock test done");
    endtask
    task automatic t_regs;
        apb(1'b0, ebrw_pkg::ADDR_CTRL, 32'h0000_0000);
        chk_v(rd, ebrw_pkg::CTRL_RESET);
        apb(1'b0, 8'h14, 32'h0000_0000);
        chk_v(err, 1'b1);
        $display("register test done");
    endtask
    task automatic t_read_write;
        cyc(32'h0000_0000, 1'b0, 16'h1234, 4'h0);
        chk_v(rd, {16'h0000, 16'h1234 ^ 16'hC3C3});
        chk_v({a_seen, 3'b000, hbe_seen}, {16'h1234, 4'h0});
        lo0 = lo;
        ld0 = ld;
        gp0 = gp;
        cyc(32'h0000_0000, 1'b1, 16'hA55A, 4'h1);
        chk_v({last_wdata, 3'b000, oe_seen}, {16'h5AA5, 4'h1});
        $display("read and write test done");
    endtask
    task automatic t_timing;
        cyc(32'h0000_0004, 1'b0, 16'h0F00, 4'h0);
        chk_c(lo >= lo0 + 4, lo, lo0);
        cyc(32'h0000_0000, 1'b0, 16'h00F0, 4'h6);
        chk_c(lo > lo0 && lo >= 6, lo, lo0);
        chk_v(rd, {16'h0000, 16'h00F0 ^ 16'hC3C3});
        cyc(32'h0000_0010, 1'b1, 16'h0101, 4'h0);
        chk_c(ld == ld0 + 1, ld, ld0);
        cyc(32'h0000_0060, 1'b0, 16'h0202, 4'h0);
        chk_c(gp > gp0, gp, gp0);
        $display("timing test done");
    endtask
    task automatic t_async;
        int ls;
        cyc(32'h0000_0000, 1'b0, 16'h3003, 4'h2);
        ls = lo;
        cyc(32'h0000_0080, 1'b0, 16'h3003, 4'h2);
        chk_c(lo > ls, lo, ls);
        chk_v(rd, {16'h0000, 16'h3003 ^ 16'hC3C3});
        $display("async ready test done");
    endtask
    // ==========================================================
    // Main sequence
    initial begin
        rst_b <= 1'b0;
        repeat (3) @(posedge clk);
        chk_v({system_clock_output, ale, read_chip_select_b, write_chip_select_b, data_oe}, 32'h0000_0006);
        rst_b <= 1'b1;
        t_clock();
        t_regs();
        t_read_write();
        t_timing();
        t_async();
        finish_test();
    end
endmodule
